/* rtl/aitg_fifo.sv */
// Module: synchronous FIFO with valid/ready on both sides
`default_nettype none
module aitg_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  aitg_stream_if.snk wr,
  aitg_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
      $error("aitg_fifo: DEPTH must be a power of two");
    end
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic full;
  logic empty;
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty = (wptr == rptr);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rptr[AW-1:0]];
  always_ff @(posedge mclk_i)
  begin
    if (wr.valid && !full)
    begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (wr.valid && !full)
      begin
        wptr <= wptr + 1'b1;
      end
      if (rd.ready && !empty)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end
  a_fifo_no_overflow: assert property (@(posedge mclk_i) disable iff (rst_i)
    full |=> (wptr == $past(wptr)) || (rptr != $past(rptr)))
    else $error("FIFO written while full");
endmodule : aitg_fifo
`default_nettype wire

/* rtl/aitg_pkg.sv */
// Package: constants of the acoustic indicator tone generator
`default_nettype none
package aitg_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int FS_HZ = 32_000;
  localparam int TICK_DIV = CLK_HZ / FS_HZ;
  localparam int MS_SAMPLES = FS_HZ / 1000;
  localparam int FADE_MS = 64;
  localparam int FADE_SAMPLES = FADE_MS * MS_SAMPLES;
  localparam int FADE_SH = $clog2(FADE_SAMPLES);
  localparam int NUM_EVENTS = 10;
  localparam int PURE_MAX = 4;
  localparam int DAMP_MAX = 6;
  localparam int AUDIO_W = 20;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int MEM_WORDS = NUM_EVENTS * 64;
  // Address = {event[3:0], component[2:0], field[2:0]}
  localparam logic [2:0] F_FREQ = 3'h0;
  localparam logic [2:0] F_AMP = 3'h1;
  localparam logic [2:0] F_START = 3'h2;
  localparam logic [2:0] F_DUR = 3'h3;
  localparam logic [2:0] F_DECAY = 3'h4;
  localparam logic [2:0] F_EVCTRL = 3'h7;
  localparam int EVCTRL_DAMPED = 3;
  localparam logic [ADDR_W-1:0] REG_DUCK = 10'h3C0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 10'h3C1;
  localparam logic [ADDR_W-1:0] REG_TRIGGER = 10'h3C2;
  localparam logic [DATA_W-1:0] DUCK_RST = 16'h4000;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [2:0] {S_IDLE, S_COMP, S_MIX, S_PUSH} aitg_state_e;
endpackage : aitg_pkg
`default_nettype wire

/* rtl/aitg_stream_if.sv */
// Interface: valid/ready sample stream between generator and FIFO
`default_nettype none
interface aitg_stream_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : aitg_stream_if
`default_nettype wire

/* rtl/aitg_top.sv */
// Module: event-driven indicator tone generator mixed into the audio path
//
// Local design decisions: the address map and strobed register access.
`default_nettype none
module aitg_top
  import aitg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DIV
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [NUM_EVENTS-1:0] event_i,
  input wire logic [AUDIO_W-1:0] audio_i,
  output logic [AUDIO_W-1:0] audio_o,
  output logic audio_valid_o,
  input wire logic audio_ready_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o
);
  initial begin
    if (TICK_CYCLES < 16)
    begin
      $error("aitg_top: TICK_CYCLES too small for one sample computation");
    end
    // The sample divider is 13 bits wide
    if (TICK_CYCLES > 8192)
    begin
      $error("aitg_top: TICK_CYCLES too large for the sample divider");
    end
  end

  logic [DATA_W-1:0] cfg [MEM_WORDS];
  logic [DATA_W-1:0] duck;
  logic [15:0] phase [DAMP_MAX];
  logic [15:0] denv [DAMP_MAX];
  aitg_state_e state;
  logic [2:0] k;
  logic [3:0] cur_ev;
  logic [3:0] pend_ev;
  logic restart_req;
  logic playing;
  logic tick;
  logic tick_pend;
  logic [12:0] div_cnt;
  logic [22:0] sound_t;
  logic [23:0] acc;
  logic any_left;
  logic [7:0] overruns;
  logic [AUDIO_W-1:0] mix;
  aitg_stream_if #(.W(AUDIO_W)) fin ();
  aitg_stream_if #(.W(AUDIO_W)) fout ();

  // Software may fire a sound by event number as well as by pin
  logic sw_trig;
  logic [NUM_EVENTS-1:0] ev_req;
  logic [3:0] ev_sel;
  assign sw_trig = wr_i && (addr_i == REG_TRIGGER) && (wdata_i < 16'(NUM_EVENTS));
  always_comb
  begin
    ev_req = event_i;
    if (sw_trig)
    begin
      ev_req[wdata_i[3:0]] = 1'b1;
    end
    ev_sel = '0;
    for (int i = NUM_EVENTS - 1; i >= 0; i--)
    begin
      if (ev_req[i])
      begin
        ev_sel = 4'(i);
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (wr_i && addr_i < ADDR_W'(MEM_WORDS))
    begin
      cfg[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      duck <= DUCK_RST;
    end
    else if (wr_i && addr_i == REG_DUCK)
    begin
      duck <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= '0;
    end
    else if (rd_i)
    begin
      if (addr_i < ADDR_W'(MEM_WORDS))
      begin
        rdata_o <= cfg[addr_i];
      end
      else if (addr_i == REG_DUCK)
      begin
        rdata_o <= duck;
      end
      else if (addr_i == REG_STATUS)
      begin
        rdata_o <= {overruns, 3'h0, playing, cur_ev};
      end
      else
      begin
        rdata_o <= '0;
      end
    end
  end

  // Sample-rate enable
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (div_cnt == 13'(TICK_CYCLES - 1));
      div_cnt <= (div_cnt == 13'(TICK_CYCLES - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  // Latest event wins; it is applied at the next sample start
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      restart_req <= 1'b0;
      pend_ev <= '0;
    end
    else if (|ev_req)
    begin
      restart_req <= 1'b1;
      pend_ev <= ev_sel;
    end
    else if (state == S_IDLE && tick_pend)
    begin
      restart_req <= 1'b0;
    end
  end

  // Per-component evaluation for slot k of the current sound
  logic [DATA_W-1:0] evctrl;
  logic damped;
  logic [2:0] n_eff;
  logic slot_on;
  logic [DATA_W-1:0] c_freq;
  logic [DATA_W-1:0] c_amp;
  logic [DATA_W-1:0] c_start;
  logic [DATA_W-1:0] c_dur;
  logic [3:0] c_shift;
  logic [22:0] st;
  logic [22:0] en;
  logic in_win;
  logic [22:0] dt;
  logic [22:0] rem;
  logic [22:0] gmin;
  logic [11:0] gain;
  logic [15:0] env_p;
  logic [15:0] env_d;
  logic [15:0] env;
  logic signed [15:0] sx;
  logic [15:0] ax;
  logic signed [33:0] sq;
  logic signed [15:0] sine;
  logic signed [32:0] prod;
  logic signed [23:0] contrib;
  always_comb
  begin
    evctrl = cfg[{cur_ev, 3'h0, F_EVCTRL}];
    damped = evctrl[EVCTRL_DAMPED];
    n_eff = evctrl[2:0];
    // Counts above the sound type's limit are clamped
    if (!damped && n_eff > 3'(PURE_MAX))
    begin
      n_eff = 3'(PURE_MAX);
    end
    if (damped && n_eff > 3'(DAMP_MAX))
    begin
      n_eff = 3'(DAMP_MAX);
    end
    slot_on = (k < n_eff) && playing;
    c_freq = cfg[{cur_ev, k, F_FREQ}];
    c_amp = cfg[{cur_ev, k, F_AMP}];
    c_start = cfg[{cur_ev, k, F_START}];
    c_dur = cfg[{cur_ev, k, F_DUR}];
    c_shift = cfg[{cur_ev, k, F_DECAY}][3:0];
    if (c_shift == 4'h0)
    begin
      c_shift = 4'h1;
    end
    st = {2'b0, c_start, 5'b0};
    en = st + {2'b0, c_dur, 5'b0};
    in_win = slot_on && (sound_t >= st) && (sound_t < en);
    dt = sound_t - st;
    rem = en - sound_t;
    gmin = (dt < rem) ? dt : rem;
    gain = (gmin > 23'(FADE_SAMPLES)) ? 12'(FADE_SAMPLES) : gmin[11:0];
    env_p = 16'((32'(c_amp) * 32'(gain)) >> FADE_SH);
    env_d = (sound_t == st) ? c_amp : denv[k];
    env = damped ? env_d : env_p;
    sx = $signed(phase[k]);
    ax = sx[15] ? 16'(-sx) : 16'(sx);
    sq = 34'(sx) * $signed({1'b0, 17'h0_8000 - {1'b0, ax}});
    sine = 16'(sq >>> 14);
    prod = 33'(sine) * $signed({1'b0, env});
    contrib = in_win ? 24'(prod >>> 16) : '0;
  end

  // Mix: attenuated audio during a sound plus the summed tones
  logic signed [36:0] duck_prod;
  logic signed [23:0] duck_term;
  logic signed [23:0] mix_sum;
  always_comb
  begin
    duck_prod = $signed(audio_i) * $signed({1'b0, duck});
    duck_term = playing ? 24'(duck_prod >>> 15) : 24'($signed(audio_i));
    mix_sum = duck_term + $signed(acc);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_pend <= 1'b0;
      overruns <= '0;
    end
    else
    begin
      if (tick)
      begin
        tick_pend <= 1'b1;
        if (tick_pend && overruns != 8'hFF)
        begin
          overruns <= overruns + 1'b1;
        end
      end
      else if (state == S_IDLE)
      begin
        tick_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      k <= '0;
      cur_ev <= '0;
      playing <= 1'b0;
      sound_t <= '0;
      acc <= '0;
      any_left <= 1'b0;
      mix <= '0;
      for (int i = 0; i < DAMP_MAX; i++)
      begin
        phase[i] <= '0;
        denv[i] <= '0;
      end
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (tick_pend)
          begin
            if (restart_req)
            begin
              cur_ev <= pend_ev;
              playing <= 1'b1;
              sound_t <= '0;
              for (int i = 0; i < DAMP_MAX; i++)
              begin
                phase[i] <= '0;
                denv[i] <= '0;
              end
            end
            k <= '0;
            acc <= '0;
            any_left <= 1'b0;
            state <= S_COMP;
          end
        end
        S_COMP:
        begin
          acc <= acc + contrib;
          if (in_win)
          begin
            phase[k] <= phase[k] + c_freq;
            denv[k] <= env_d - (env_d >> c_shift);
          end
          if (slot_on && sound_t < en)
          begin
            any_left <= 1'b1;
          end
          k <= k + 1'b1;
          if (k == 3'(DAMP_MAX - 1))
          begin
            state <= S_MIX;
          end
        end
        S_MIX:
        begin
          if (mix_sum > 24'sd524287)
          begin
            mix <= 20'h7_FFFF;
          end
          else if (mix_sum < -24'sd524288)
          begin
            mix <= 20'h8_0000;
          end
          else
          begin
            mix <= mix_sum[AUDIO_W-1:0];
          end
          if (playing)
          begin
            sound_t <= sound_t + 1'b1;
            playing <= any_left;
          end
          state <= S_PUSH;
        end
        S_PUSH:
        begin
          // A full FIFO holds the engine here; late ticks show as overruns
          if (fin.ready)
          begin
            state <= S_IDLE;
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  assign fin.valid = (state == S_PUSH);
  assign fin.data = mix;
  assign fout.ready = !audio_valid_o || audio_ready_i;

  aitg_fifo #(.W(AUDIO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr(fin),
    .rd(fout)
  );

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      audio_valid_o <= 1'b0;
      audio_o <= '0;
    end
    else if (fout.ready)
    begin
      audio_valid_o <= fout.valid;
      if (fout.valid)
      begin
        audio_o <= fout.data;
      end
    end
  end

  a_event_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
    event_i[9] && !(|event_i[8:0]) && !sw_trig |=> restart_req && pend_ev == 4'd9)
    else $error("Event 9 not latched");
  a_sound_kind: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP && damped && in_win && sound_t != st |-> env == denv[k])
    else $error("Damped sound used a pure envelope");
  a_pure_limit: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP && !damped && k >= 3'(PURE_MAX) |-> contrib == 0)
    else $error("Pure sound exceeded four components");
  a_fade_ramp: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP && in_win && dt < 23'(FADE_SAMPLES) && dt <= rem
    |-> gain == dt[11:0])
    else $error("Fade ramp does not track elapsed time");
  a_fade_begin: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP && !damped && slot_on && sound_t == st |-> env == 16'h0)
    else $error("Pure component not silent at fade start");
  a_dur_end: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP && sound_t >= en |-> contrib == 0)
    else $error("Component sounds after its duration");
  a_damp_limit: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP |-> n_eff <= 3'(DAMP_MAX))
    else $error("Damped sound exceeded six components");
  a_damp_onset: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_COMP && damped && in_win && sound_t == st ##1 state == S_COMP
    |-> denv[$past(k)] == $past(c_amp) - ($past(c_amp) >> $past(c_shift)))
    else $error("Damped component did not start at full level");
  a_duck_path: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_MIX && !playing && acc == 0 |=> mix == $past(audio_i))
    else $error("Audio path altered while idle");
  a_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    state == S_IDLE && tick_pend && restart_req
    |=> playing && sound_t == 0 && cur_ev == $past(pend_ev) && state == S_COMP)
    else $error("Event did not restart playback");
endmodule : aitg_top
`default_nettype wire

/* tb/aitg_sink.sv */
// Downstream audio path model: takes samples with random stalls
`default_nettype none
module aitg_sink
  import aitg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic valid_i,
  input wire logic [AUDIO_W-1:0] data_i,
  output logic ready_o,
  output logic got_o,
  output logic [AUDIO_W-1:0] sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 98474;
  // Ready only moves right after an edge; a sample counts at the edge it is taken
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_o <= 1'b0;
      got_o <= 1'b0;
      sample_o <= '0;
    end
    else
    begin
      got_o <= valid_i && ready_o;
      sample_o <= data_i;
      ready_o <= !hold_i && ($random(seed) % 4 != 0);
    end
  end
endmodule : aitg_sink
`default_nettype wire

/* tb/tb.sv */
// Testbench: tone generator against the audio path model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aitg_pkg::*;
  localparam int TK = 32;
  logic mclk_i, rst_i, wr_i, rd_i, audio_ready_i, audio_valid_o, hold, got, seen;
  logic [NUM_EVENTS-1:0] event_i;
  logic [AUDIO_W-1:0] audio_i, audio_o, smp, v;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, rv, k;
  logic signed [39:0] p;
  logic [AUDIO_W-1:0] expq[$];
  int n_fail, samples_checked, seed;

  aitg_top #(.TICK_CYCLES(TK)) u_aitg_top (.mclk_i(mclk_i), .rst_i(rst_i),
    .event_i(event_i), .audio_i(audio_i), .audio_o(audio_o),
    .audio_valid_o(audio_valid_o), .audio_ready_i(audio_ready_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  aitg_sink u_aitg_sink (.mclk_i(mclk_i), .rst_i(rst_i), .hold_i(hold),
    .valid_i(audio_valid_o), .data_i(audio_o), .ready_o(audio_ready_i), .got_o(got),
    .sample_o(smp));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge mclk_i);
  endtask : ticks

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd

  // One component per sound keeps the expected output exact
  task automatic cfg(input int ev, input logic dmp, input logic [15:0] amp,
                     input logic [15:0] st, input logic [15:0] dur);
    logic [6:0] b;
    b = {ev[3:0], 3'h0};
    wr({b, F_FREQ}, 16'h0800);
    wr({b, F_AMP}, amp);
    wr({b, F_START}, st);
    wr({b, F_DUR}, dur);
    wr({b, F_DECAY}, 16'h0004);
    wr({b, F_EVCTRL}, {12'h000, dmp, 3'h1});
  endtask : cfg

  task automatic fire(input int ev, input logic sw);
    if (sw)
      wr(REG_TRIGGER, 16'(ev));
    else
    begin
      @(posedge mclk_i);
      event_i <= NUM_EVENTS'(1) << ev;
      @(posedge mclk_i);
      event_i <= '0;
    end
  endtask : fire

  always @(posedge mclk_i)
  begin
    if (got)
    begin
      if (smp !== '0)
        seen = 1'b1;
      if (expq.size() > 0)
        check(smp, expq.pop_front());
    end
  end

  initial
  begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    seed = 98474;
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    hold = 1'b0;
    event_i = '0;
    audio_i = '0;
    addr_i = '0;
    wdata_i = '0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    check(audio_valid_o, 1'b0);
    check(rdata_o, 16'h0000);
    rd(REG_DUCK);
    check(rv, DUCK_RST);
    rd(10'h3FF);
    check(rv, 16'h0000);
    wr(REG_STATUS, 16'hFFFF);
    rd(REG_STATUS);
    check(rv[4], 1'b0);
    // Every event, six by pin and four by software (those with e[1] set), with a random duck gain
    for (int e = 0; e < NUM_EVENTS; e++)
    begin
      v = AUDIO_W'($random(seed)) & 20'hF_FFF8;
      k = 16'($random(seed)) & 16'h7000;
      audio_i <= v;
      wr(REG_DUCK, k);
      cfg(e, e[0], 16'h0000, 16'h0000, 16'h0002);
      ticks(40);
      repeat (4) expq.push_back(v);
      ticks(8);
      fire(e, e[1]);
      ticks(6);
      rd(REG_STATUS);
      check(rv[4:0], {1'b1, e[3:0]});
      p = $signed(v) * $signed({1'b0, k});
      repeat (8) expq.push_back(p[34:15]);
      ticks(70);
      rd(REG_STATUS);
      check(rv[4], 1'b0);
    end
    // Restart in mid-sound; two events at once, lower index wins
    cfg(5, 1'b0, 16'h0000, 16'h0000, 16'h0003);
    fire(5, 1'b0);
    ticks(60);
    @(posedge mclk_i);
    event_i <= 10'h0A0;
    @(posedge mclk_i);
    event_i <= '0;
    ticks(50);
    rd(REG_STATUS);
    check(rv[4:0], 5'h15);
    // Start offset silence, then a tone, for pure and damped sounds
    audio_i <= '0;
    for (int d = 0; d < 2; d++)
    begin
      cfg(0, d[0], 16'hFFFF, 16'h0001, 16'h0004);
      ticks(40);
      fire(0, 1'b0);
      ticks(2);
      repeat (16) expq.push_back('0);
      ticks(30);
      seen = 1'b0;
      ticks(100);
      check(seen, 1'b1);
      ticks(18);
      rd(REG_STATUS);
      check(rv[4], 1'b1);
      ticks(25);
      rd(REG_STATUS);
      check(rv[4], 1'b0);
    end
    // Stall the path until the buffer refuses, then drain it
    hold <= 1'b1;
    ticks(45);
    rd(REG_STATUS);
    check(rv[15:8] != 8'h00, 1'b1);
    check(audio_valid_o, 1'b1);
    hold <= 1'b0;
    for (int i = 0; i < 4000 && audio_valid_o !== 1'b0; i++)
      @(posedge mclk_i);
    check(audio_valid_o, 1'b0);
    for (int i = 0; i < 4000 && expq.size() > 0; i++)
      @(posedge mclk_i);
    check(expq.size(), 0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
